// >>> shared/kms_pkg.sv
package kms_pkg;

  // ---------------------------------------------------------------
  // Matrix size
  // ---------------------------------------------------------------
  localparam int unsigned NUM_ROWS = 5;
  localparam int unsigned NUM_COLS = 5;

  // ---------------------------------------------------------------
  // Column drive patterns
  // ---------------------------------------------------------------
  localparam logic [4:0] COLS_ALL_HIGH = 5'h1f;
  localparam logic [4:0] COLS_ALL_LOW  = 5'h00;
  localparam logic [4:0] ROWS_IDLE     = 5'h1f;
  localparam logic [2:0] FIRST_COL     = 3'h0;
  localparam logic [2:0] LAST_COL      = 3'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYC    =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] SETTLE_LAST    = 5'(SETTLE_CYC - 1);

  // ---------------------------------------------------------------
  // Scan states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_IDLE  = 3'b001,
    ST_HIGH  = 3'b010,
    ST_COL   = 3'b011,
    ST_DONE  = 3'b100
  } kms_state_t;

endpackage

// >>> src/kms_row_sync.sv
module kms_row_sync (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Rows
  input  wire logic [4:0] rowAsync,
  output logic      [4:0] rowStable
);

  // ---------------------------------------------------------------
  // Three-stage sampling
  // ---------------------------------------------------------------
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic [4:0] s3_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= kms_pkg::ROWS_IDLE;
      s2_q <= kms_pkg::ROWS_IDLE;
      s3_q <= kms_pkg::ROWS_IDLE;
    end else begin
      s1_q <= rowAsync;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ---------------------------------------------------------------
  // Change accepted once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rowStable <= kms_pkg::ROWS_IDLE;
    end else begin
      for (int i = 0; i < kms_pkg::NUM_ROWS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          rowStable[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // kms_row_sync

// >>> src/kms_scanner.sv
// Function
// - Five row inputs, 0 to 4, sense the matrix rows.
// - Five column outputs, 0 to 4, drive the matrix columns.
// - Idle: rows pulled high, all columns driven low.
// - Any press while columns idle low raises the interrupt.
// - Reset all high; scan all high, each column low 0..4, all low.
// - All rows sampled while each column is driven low.
module kms_scanner (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Key matrix
  input  wire logic [4:0]  keyRowIn,
  output logic      [4:0]  keyColOut,
  // Microcontroller side
  input  wire logic        scanStart,
  output logic             keyIrq,
  output logic             scanBusy,
  output logic [24:0]      keyMap,
  output logic             mapValid,
  output logic             powerKey
);

  // ---------------------------------------------------------------
  // Row synchroniser
  // ---------------------------------------------------------------
  logic [4:0] rowSync;

  kms_row_sync u_sync (
    .mclk      (mclk),
    .resetn    (resetn),
    .rowAsync  (keyRowIn),
    .rowStable (rowSync)
  );

  // ---------------------------------------------------------------
  // Column pattern with one line low
  // ---------------------------------------------------------------
  function automatic logic [4:0] col_low(input logic [2:0] col);
    return ~(5'h01 << col);
  endfunction

  // ---------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------
  kms_pkg::kms_state_t state_q;
  logic [2:0]          col_q;
  logic [4:0]          settle_q;
  logic                settled;

  assign settled = (settle_q == kms_pkg::SETTLE_LAST);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= kms_pkg::ST_RESET;
    end else begin
      unique case (state_q)
        kms_pkg::ST_RESET: state_q <= kms_pkg::ST_IDLE;
        kms_pkg::ST_IDLE: begin
          if (scanStart) begin
            state_q <= kms_pkg::ST_HIGH;
          end
        end
        kms_pkg::ST_HIGH: begin
          if (settled) begin
            state_q <= kms_pkg::ST_COL;
          end
        end
        kms_pkg::ST_COL: begin
          if (settled && col_q == kms_pkg::LAST_COL) begin
            state_q <= kms_pkg::ST_DONE;
          end
        end
        kms_pkg::ST_DONE: state_q <= kms_pkg::ST_IDLE;
        default: state_q <= kms_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 5'h00;
    end else if ((state_q == kms_pkg::ST_HIGH || state_q == kms_pkg::ST_COL) && !settled) begin
      settle_q <= settle_q + 5'h01;
    end else begin
      settle_q <= 5'h00;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      col_q <= kms_pkg::FIRST_COL;
    end else if (state_q != kms_pkg::ST_COL) begin
      col_q <= kms_pkg::FIRST_COL;
    end else if (settled) begin
      col_q <= col_q + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Column drive
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keyColOut <= kms_pkg::COLS_ALL_HIGH;
    end else begin
      unique case (state_q)
        kms_pkg::ST_HIGH: begin
          if (settled) begin
            keyColOut <= col_low(kms_pkg::FIRST_COL);
          end else begin
            keyColOut <= kms_pkg::COLS_ALL_HIGH;
          end
        end
        kms_pkg::ST_COL: begin
          if (settled && col_q == kms_pkg::LAST_COL) begin
            keyColOut <= kms_pkg::COLS_ALL_LOW;
          end else if (settled) begin
            keyColOut <= col_low(col_q + 3'h1);
          end
        end
        kms_pkg::ST_IDLE: begin
          if (scanStart) begin
            keyColOut <= kms_pkg::COLS_ALL_HIGH;
          end else begin
            keyColOut <= kms_pkg::COLS_ALL_LOW;
          end
        end
        default: keyColOut <= kms_pkg::COLS_ALL_LOW;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Row sampling per column
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keyMap <= 25'h0000000;
    end else if (state_q == kms_pkg::ST_HIGH) begin
      keyMap <= 25'h0000000;
    end else if (state_q == kms_pkg::ST_COL && settled) begin
      keyMap[col_q*kms_pkg::NUM_ROWS +: kms_pkg::NUM_ROWS] <= ~rowSync;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mapValid <= 1'b0;
    end else if (state_q == kms_pkg::ST_HIGH) begin
      mapValid <= 1'b0;
    end else if (state_q == kms_pkg::ST_DONE) begin
      mapValid <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scanBusy <= 1'b0;
    end else begin
      scanBusy <= (state_q == kms_pkg::ST_IDLE && scanStart)
                || state_q == kms_pkg::ST_HIGH
                || (state_q == kms_pkg::ST_COL && !(settled && col_q == kms_pkg::LAST_COL));
    end
  end

  // ---------------------------------------------------------------
  // Press detection
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keyIrq   <= 1'b0;
      powerKey <= 1'b0;
    end else begin
      keyIrq   <= (state_q == kms_pkg::ST_IDLE)
                && (keyColOut == kms_pkg::COLS_ALL_LOW)
                && (rowSync != kms_pkg::ROWS_IDLE);
      powerKey <= ~rowSync[4];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  idle_cols_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_IDLE && $past(state_q) == kms_pkg::ST_IDLE && !$past(scanStart))
      |-> keyColOut == kms_pkg::COLS_ALL_LOW)
    else $error("columns not low while idle");

  press_irq_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_IDLE && keyColOut == kms_pkg::COLS_ALL_LOW
      && rowSync != kms_pkg::ROWS_IDLE) |=> keyIrq)
    else $error("press while idle gave no interrupt");

  scan_high_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_IDLE && scanStart)
      |=> keyColOut == kms_pkg::COLS_ALL_HIGH && state_q == kms_pkg::ST_HIGH)
    else $error("scan did not start all high");

  one_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_COL) |-> $onehot(~keyColOut) && !keyColOut[col_q])
    else $error("scan column drive wrong");

  scan_end_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_DONE)
      |-> keyColOut == kms_pkg::COLS_ALL_LOW && $past(col_q) == kms_pkg::LAST_COL)
    else $error("scan did not end all low after column 4");

  row_sample_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_COL && settled)
      |=> keyMap[$past(col_q)*kms_pkg::NUM_ROWS +: kms_pkg::NUM_ROWS] == ~$past(rowSync))
    else $error("row sample not stored");

  map_done_a: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == kms_pkg::ST_DONE) |=> mapValid && !scanBusy)
    else $error("scan end not flagged");

  power_key_a: assert property (@(posedge mclk) disable iff (!resetn)
    !rowSync[4] |=> powerKey)
    else $error("power key not reported");

endmodule // kms_scanner

// >>> test/kms_key_matrix.sv
module kms_key_matrix (
  // Matrix pins
  input  wire logic [4:0]  keyColOut,
  output logic      [4:0]  keyRowIn,
  // Pressed keys, bit c*4+r
  input  wire logic [19:0] keyDown,
  input  wire logic        powerDown
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------
  // Passive switches over pulled-up rows
  // --------------------------------------------------------------
  always_comb begin
    keyRowIn = 5'h1f;
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (keyDown[c*4+r] && !keyColOut[c]) keyRowIn[r] = 1'b0;
      end
    end
    if (powerDown) keyRowIn[4] = 1'b0;
  end
endmodule // kms_key_matrix

// >>> test/keypad_matrix_scanner_test.sv
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin bad_count++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module keypad_matrix_scanner_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, resetn, scanStart, keyIrq, scanBusy, mapValid, powerKey, powerDown;
  logic [4:0]  keyRowIn, keyColOut;
  logic [19:0] keyDown;
  logic [24:0] keyMap;
  logic [31:0] seed;
  int          bad_count, n_tests;

  kms_scanner i_dut (.mclk(mclk), .resetn(resetn), .keyRowIn(keyRowIn),
    .keyColOut(keyColOut), .scanStart(scanStart), .keyIrq(keyIrq), .scanBusy(scanBusy),
    .keyMap(keyMap), .mapValid(mapValid), .powerKey(powerKey));
  kms_key_matrix i_keys (.keyColOut(keyColOut), .keyRowIn(keyRowIn), .keyDown(keyDown),
    .powerDown(powerDown));

  always #25 mclk = ~mclk;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [24:0] exp_map(input logic [19:0] k, input logic p);
    logic [24:0] m;
    m = '0;
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 4; r++) m[c*5+r] = k[c*4+r];
      m[c*5+4] = p;
    end
    return m;
  endfunction

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_hi(input bit pickValid);
    int i;
    i = 0;
    while (i < 6 && (pickValid ? mapValid : scanBusy) !== 1'b1) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if ((pickValid ? mapValid : scanBusy) !== 1'b1) begin
      bad_count++;
      $display("BAD %s exp 1 got 0", pickValid ? "mapValid" : "scanBusy");
      print_verdict();
    end
  endtask

  task automatic round(input logic [19:0] k, input logic p);
    @(posedge mclk);
    keyDown   <= k;
    powerDown <= p;
    repeat (8) @(posedge mclk);
    #1;
    `CHK("keyIrq", (|{k, p}), keyIrq)
    `CHK("powerKey", p, powerKey)
    @(posedge mclk);
    scanStart <= 1'b1;
    @(posedge mclk);
    scanStart <= 1'b0;
    #1;
    wait_hi(1'b0);
    `CHK("colHigh", 5'h1f, keyColOut)
    for (int c = 0; c < 5; c++) begin
      for (int j = 0; j < 20; j++) begin
        @(posedge mclk);
        scanStart <= (c == 2 && j == 5);
      end
      #1;
      `CHK("colLow", ~(5'h01 << c), keyColOut)
      `CHK("busyScan", 1'b1, scanBusy)
      `CHK("irqScan", 1'b0, keyIrq)
      `CHK("validScan", 1'b0, mapValid)
    end
    repeat (20) @(posedge mclk);
    #1;
    `CHK("colEnd", 5'h00, keyColOut)
    `CHK("busyEnd", 1'b0, scanBusy)
    `CHK("validEnd", 1'b0, mapValid)
    wait_hi(1'b1);
    `CHK("keyMap", exp_map(k, p), keyMap)
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    scanStart = 1'b0;
    keyDown = '0;
    powerDown = 1'b0;
    seed = 32'd32190;
    bad_count = 0;
    n_tests = 0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    `CHK("colReset", 5'h1f, keyColOut)
    `CHK("validReset", 1'b0, mapValid)
    repeat (3) @(posedge mclk);
    #1;
    `CHK("colIdle", 5'h00, keyColOut)
    for (int n = 0; n < 9; n++) begin
      seed = xs(seed);
      case (n)
        0: round(20'h00000, 1'b0);
        1: round(20'hfffff, 1'b1);
        2: round(20'h80000, 1'b0);
        3: round(20'h00001, 1'b1);
        default: round(seed[19:0], seed[20]);
      endcase
    end
    print_verdict();
  end
endmodule // keypad_matrix_scanner_test
